// *** core/lvs_pkg.sv ***
package lvs_pkg;
  localparam int PHASES = 3;
  localparam int SMP_W = 16;
  localparam int DATA_W = 24;

  // register addresses
  localparam logic [7:0] A_VMAX = 8'h0e;
  localparam logic [7:0] A_PERIOD = 8'h10;
  localparam logic [7:0] A_MEASUREMENT_MODE_REG = 8'h14;
  localparam logic [7:0] A_LCMODE = 8'h17;
  localparam logic [7:0] A_MASK = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h19;
  localparam logic [7:0] A_STATUS_READ_CLEAR = 8'h1a;
  localparam logic [7:0] A_ZERO_CROSS_TIMEOUT_VALUE = 8'h1b;
  localparam logic [7:0] A_CAL_A = 8'h3f;
  localparam logic [7:0] A_CAL_B = 8'h40;
  localparam logic [7:0] A_CAL_C = 8'h41;
  localparam logic [7:0] A_DIP_THR = 8'h49;
  localparam logic [7:0] A_DIP_CYC = 8'h4a;

  // reset values and field positions
  localparam logic [15:0] ZERO_CROSS_TIMEOUT_VALUE_RST = 16'hffff;
  localparam int DIP_BIT0 = 1;
  localparam int TMO_BIT0 = 9;
  localparam int MM_PEAK_LSB = 2;
  localparam int LC_ZERO_CROSS_SELECT_LSB = 3;
  localparam int LC_SHOW_PERIOD = 7;
  localparam int MAG_LSB = 6;

  // timing
  localparam int TMO_TICK_CYC = 384;
  localparam int PERIOD_LSB_CYC = 96;
  localparam int PERIOD_AVG = 4;
  localparam int LINE_PERIOD_VALUE_LSB_PER_HZ = 16;
  localparam int REF_CLK_MHZ = 10;
  localparam int DELAY_STEP_NS = 1200;
  localparam int ADVANCE_STEP_NS = 2400;
  localparam int DELAY_STEP_CYC = DELAY_STEP_NS * REF_CLK_MHZ / 1000;
  localparam int ADVANCE_STEP_CYC = ADVANCE_STEP_NS * REF_CLK_MHZ / 1000;
  localparam int CAL_BASE_CYC = 64 * ADVANCE_STEP_CYC;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } reg_rsp_s;

  typedef struct packed {
    logic [PHASES-1:0] valid;
    logic [PHASES-1:0][SMP_W-1:0] data;
  } volt_in_s;
endpackage : lvs_pkg

// *** core/phase_delay_line.sv ***
`timescale 1ns/1ps
module phase_delay_line #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // incoming sample
  input wire logic in_valid,
  input wire logic [15:0] in_sample,
  input wire logic [6:0] cal,
  // shifted sample
  output logic out_valid,
  output logic [15:0] out_sample
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [11:0] timer;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [DEPTH-1:0][15:0] smp;
    logic [DEPTH-1:0][11:0] due;
    logic ov;
    logic [15:0] osmp;
  } dl_s;

  dl_s s;
  dl_s next_s;
  logic pop;
  logic push;

  // a zero delay would wait a full timer wrap, so the shortest is one cycle
  function automatic logic [11:0] delay_of(logic [6:0] c);
    logic [11:0] mag;
    logic [11:0] d;
    mag = c[6] ? 12'(7'(~c + 7'h1)) : 12'(c);
    if (c[6]) begin
      d = 12'(lvs_pkg::CAL_BASE_CYC) - 12'(mag * 12'(lvs_pkg::ADVANCE_STEP_CYC));
    end else begin
      d = 12'(lvs_pkg::CAL_BASE_CYC) + 12'(mag * 12'(lvs_pkg::DELAY_STEP_CYC));
    end
    return (d == 12'h0) ? 12'h1 : d;
  endfunction : delay_of

  always_comb begin
    next_s = s;
    next_s.timer = s.timer + 12'h1;
    next_s.ov = 1'b0;
    pop = (s.cnt != '0) && (s.timer == s.due[s.rp]);
    push = in_valid && ((s.cnt != (AW+1)'(DEPTH)) || pop);
    if (pop) begin
      next_s.ov = 1'b1;
      next_s.osmp = s.smp[s.rp];
      next_s.rp = s.rp + 1'b1;
    end
    if (push) begin
      next_s.smp[s.wp] = in_sample;
      next_s.due[s.wp] = s.timer + delay_of(cal);
      next_s.wp = s.wp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_valid = s.ov;
  assign out_sample = s.osmp;

  a_delay_not_early:
  assert property (@(posedge clk) disable iff (rst)
    in_valid && !cal[6] && s.cnt == '0 |=> !out_valid [*8])
    else $error("delayed sample left too early");
  a_delay_has_entry:
  assert property (@(posedge clk) disable iff (rst)
    out_valid |-> $past(s.cnt) != '0)
    else $error("sample emitted from an empty delay line");
endmodule : phase_delay_line

// *** core/line_voltage_supervisor.sv ***
`timescale 1ns/1ps
module line_voltage_supervisor #(
  parameter int CLK_HZ = 125_000_000,
  parameter int PEAK_ZX_COUNT = 2,
  parameter int DELAY_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire lvs_pkg::reg_req_s reg_req,
  output lvs_pkg::reg_rsp_s reg_rsp,
  // filtered voltage samples
  input wire lvs_pkg::volt_in_s volt_in,
  // interrupt request
  output logic irq_n
);
  localparam int NP = lvs_pkg::PHASES;
  localparam int DW = lvs_pkg::DATA_W;
  localparam logic [8:0] PRE_LAST = 9'(lvs_pkg::TMO_TICK_CYC - 1);
  localparam logic [6:0] UNIT_LAST = 7'(lvs_pkg::PERIOD_LSB_CYC - 1);
  localparam logic [1:0] AVG_LAST = 2'(lvs_pkg::PERIOD_AVG - 1);
  localparam logic [31:0] LINE_PERIOD_VALUE_NUM =
    32'(lvs_pkg::LINE_PERIOD_VALUE_LSB_PER_HZ * (CLK_HZ / lvs_pkg::PERIOD_LSB_CYC));
  localparam logic [7:0] PEAK_LAST = 8'(PEAK_ZX_COUNT - 1);
  localparam int TMO_GAP = lvs_pkg::TMO_TICK_CYC;

  typedef struct packed {
    logic [15:0] zero_cross_timeout_value;
    logic [NP-1:0][6:0] cal;
    logic [7:0] measurement_mode_reg;
    logic [7:0] lcmode;
    logic [7:0] dip_thr;
    logic [7:0] dip_cyc;
    logic [DW-1:0] mask;
    logic [DW-1:0] status;
    logic [8:0] pre;
    logic [NP-1:0][15:0] tmo;
    logic [NP-1:0] prev_neg;
    logic [NP-1:0] half_low;
    logic [NP-1:0][7:0] dip_cnt;
    logic [6:0] unit;
    logic [17:0] pacc;
    logic [1:0] pn;
    logic prun;
    logic [11:0] period;
    logic dbusy;
    logic [4:0] dcnt;
    logic [31:0] dnum;
    logic [31:0] dquo;
    logic [12:0] drem;
    logic [11:0] line_period_value;
    logic [7:0] pk_run;
    logic [7:0] pk_cnt;
    logic [7:0] vmax;
    lvs_pkg::reg_rsp_s rsp;
    logic irq_n;
  } st_s;

  localparam st_s ST_RST = '{zero_cross_timeout_value: lvs_pkg::ZERO_CROSS_TIMEOUT_VALUE_RST, irq_n: 1'b1, default: '0};

  st_s s;
  st_s next_s;
  logic [NP-1:0] dval;
  logic [NP-1:0][15:0] dsmp;
  logic [NP-1:0] zx;
  logic tick;
  logic [DW-1:0] set;
  logic [DW-1:0] clr;

  // absolute value of a sample, scaled to the 8-bit compare range
  function automatic logic [7:0] mag8(logic [15:0] smp);
    logic [15:0] a;
    a = smp[15] ? (~smp + 16'h1) : smp;
    return a[lvs_pkg::MAG_LSB +: 8];
  endfunction : mag8

  for (genvar g = 0; g < NP; g++) begin : g_dly
    phase_delay_line #(
      .DEPTH(DELAY_DEPTH)
    ) u_dly (
      .clk(clk),
      .rst(rst),
      .in_valid(volt_in.valid[g]),
      .in_sample(volt_in.data[g]),
      .cal(s.cal[g]),
      .out_valid(dval[g]),
      .out_sample(dsmp[g])
    );
    assign zx[g] = dval[g] && s.prev_neg[g] && !dsmp[g][15];
  end

  always_comb begin
    logic [7:0] m;
    logic low;
    logic [7:0] pk;
    logic [1:0] psel;
    logic [12:0] rem_sh;
    logic qb;
    m = '0;
    low = 1'b0;
    pk = s.pk_run;
    psel = (s.measurement_mode_reg[1:0] == 2'h3) ? 2'h0 : s.measurement_mode_reg[1:0];
    rem_sh = '0;
    qb = 1'b0;
    next_s = s;
    set = '0;
    clr = '0;
    tick = (s.pre == PRE_LAST);
    next_s.pre = tick ? 9'h0 : s.pre + 9'h1;
    next_s.rsp.valid = 1'b0;

    for (int i = 0; i < NP; i++) begin
      if (zx[i]) begin
        next_s.tmo[i] = s.zero_cross_timeout_value;
      end else if (tick && s.tmo[i] != 16'h0) begin
        next_s.tmo[i] = s.tmo[i] - 16'h1;
        if (s.tmo[i] == 16'h1) begin
          set[lvs_pkg::TMO_BIT0 + i] = 1'b1;
        end
      end
      if (dval[i]) begin
        m = mag8(dsmp[i]);
        low = s.dip_thr > m;
        next_s.prev_neg[i] = dsmp[i][15];
        if (dsmp[i][15] != s.prev_neg[i]) begin
          // a sign change closes the half cycle just counted
          next_s.half_low[i] = low;
          if (s.half_low[i]) begin
            if (s.dip_cnt[i] != 8'hff) begin
              next_s.dip_cnt[i] = s.dip_cnt[i] + 8'h1;
            end
            if (s.dip_cyc != 8'h0 && 8'(s.dip_cnt[i] + 8'h1) == s.dip_cyc) begin
              set[lvs_pkg::DIP_BIT0 + i] = 1'b1;
            end
          end else begin
            next_s.dip_cnt[i] = 8'h0;
          end
        end else begin
          next_s.half_low[i] = s.half_low[i] & low;
        end
        if (s.measurement_mode_reg[lvs_pkg::MM_PEAK_LSB + i] && m > pk) begin
          pk = m;
        end
      end
    end

    // peak capture window counted in recognised crossings
    next_s.pk_run = pk;
    if (|(zx & s.lcmode[lvs_pkg::LC_ZERO_CROSS_SELECT_LSB +: NP])) begin
      if (s.pk_cnt >= PEAK_LAST) begin
        next_s.vmax = pk;
        next_s.pk_run = 8'h0;
        next_s.pk_cnt = 8'h0;
      end else begin
        next_s.pk_cnt = s.pk_cnt + 8'h1;
      end
    end

    // period in units of 96 clocks, averaged over four periods
    next_s.unit = (s.unit == UNIT_LAST) ? 7'h0 : s.unit + 7'h1;
    if (s.unit == UNIT_LAST && s.pacc != '1) begin
      next_s.pacc = s.pacc + 18'h1;
    end
    if (zx[psel]) begin
      if (!s.prun || s.pn == AVG_LAST) begin
        next_s.prun = 1'b1;
        next_s.pn = 2'h0;
        next_s.pacc = 18'h0;
        // the crossing cycle is the first cycle of the new unit, so 4 periods give 4x units
        next_s.unit = 7'h1;
      end else begin
        next_s.pn = s.pn + 2'h1;
      end
      if (s.prun && s.pn == AVG_LAST) begin
        next_s.period = (|s.pacc[17:14]) ? 12'hfff : s.pacc[13:2];
        next_s.dbusy = 1'b1;
        next_s.dcnt = 5'h1f;
        next_s.dnum = LINE_PERIOD_VALUE_NUM;
        next_s.dquo = 32'h0;
        next_s.drem = 13'h0;
      end
    end

    // serial restoring divide, one quotient bit per clock
    if (s.dbusy) begin
      rem_sh = {s.drem[11:0], s.dnum[31]};
      qb = rem_sh >= {1'b0, s.period};
      next_s.drem = qb ? rem_sh - {1'b0, s.period} : rem_sh;
      next_s.dnum = {s.dnum[30:0], 1'b0};
      next_s.dquo = {s.dquo[30:0], qb};
      next_s.dcnt = s.dcnt - 5'h1;
      if (s.dcnt == 5'h0) begin
        next_s.dbusy = 1'b0;
        next_s.line_period_value = (|s.dquo[30:11]) ? 12'hfff : {s.dquo[10:0], qb};
      end
    end

    if (reg_req.wr) begin
      if (reg_req.addr == lvs_pkg::A_ZERO_CROSS_TIMEOUT_VALUE) begin
        next_s.zero_cross_timeout_value = reg_req.wdata[15:0];
      end else if (reg_req.addr == lvs_pkg::A_CAL_A) begin
        next_s.cal[0] = reg_req.wdata[6:0];
      end else if (reg_req.addr == lvs_pkg::A_CAL_B) begin
        next_s.cal[1] = reg_req.wdata[6:0];
      end else if (reg_req.addr == lvs_pkg::A_CAL_C) begin
        next_s.cal[2] = reg_req.wdata[6:0];
      end else if (reg_req.addr == lvs_pkg::A_MEASUREMENT_MODE_REG) begin
        next_s.measurement_mode_reg = reg_req.wdata[7:0];
      end else if (reg_req.addr == lvs_pkg::A_LCMODE) begin
        next_s.lcmode = reg_req.wdata[7:0];
      end else if (reg_req.addr == lvs_pkg::A_DIP_THR) begin
        next_s.dip_thr = reg_req.wdata[7:0];
      end else if (reg_req.addr == lvs_pkg::A_DIP_CYC) begin
        next_s.dip_cyc = reg_req.wdata[7:0];
      end else if (reg_req.addr == lvs_pkg::A_MASK) begin
        next_s.mask = reg_req.wdata;
      end
    end

    if (reg_req.rd) begin
      next_s.rsp.valid = 1'b1;
      if (reg_req.addr == lvs_pkg::A_ZERO_CROSS_TIMEOUT_VALUE) begin
        next_s.rsp.data = DW'(s.zero_cross_timeout_value);
      end else if (reg_req.addr == lvs_pkg::A_CAL_A) begin
        next_s.rsp.data = DW'(s.cal[0]);
      end else if (reg_req.addr == lvs_pkg::A_CAL_B) begin
        next_s.rsp.data = DW'(s.cal[1]);
      end else if (reg_req.addr == lvs_pkg::A_CAL_C) begin
        next_s.rsp.data = DW'(s.cal[2]);
      end else if (reg_req.addr == lvs_pkg::A_MEASUREMENT_MODE_REG) begin
        next_s.rsp.data = DW'(s.measurement_mode_reg);
      end else if (reg_req.addr == lvs_pkg::A_LCMODE) begin
        next_s.rsp.data = DW'(s.lcmode);
      end else if (reg_req.addr == lvs_pkg::A_DIP_THR) begin
        next_s.rsp.data = DW'(s.dip_thr);
      end else if (reg_req.addr == lvs_pkg::A_DIP_CYC) begin
        next_s.rsp.data = DW'(s.dip_cyc);
      end else if (reg_req.addr == lvs_pkg::A_MASK) begin
        next_s.rsp.data = s.mask;
      end else if (reg_req.addr == lvs_pkg::A_PERIOD) begin
        next_s.rsp.data = s.lcmode[lvs_pkg::LC_SHOW_PERIOD] ? DW'(s.period) : DW'(s.line_period_value);
      end else if (reg_req.addr == lvs_pkg::A_VMAX) begin
        next_s.rsp.data = DW'(s.vmax);
      end else if (reg_req.addr == lvs_pkg::A_STATUS) begin
        next_s.rsp.data = s.status;
      end else if (reg_req.addr == lvs_pkg::A_STATUS_READ_CLEAR) begin
        next_s.rsp.data = s.status;
        clr = s.status;
      end else begin
        next_s.rsp.data = '0;
      end
    end

    // an event in the clearing cycle survives the clear
    next_s.status = (s.status & ~clr) | set;
    next_s.irq_n = ~|(next_s.status & next_s.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rsp = s.rsp;
  assign irq_n = s.irq_n;

  a_zero_cross_timeout_value_reset_ones:
  assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> s.zero_cross_timeout_value == 16'hffff)
    else $error("timeout value not all ones after reset");
  a_tick_spacing:
  assert property (@(posedge clk) disable iff (rst)
    tick |-> ##[TMO_GAP:TMO_GAP] tick)
    else $error("timeout tick spacing wrong");
  a_irq_gating:
  assert property (@(posedge clk) disable iff (rst)
    !irq_n |-> |(s.status & s.mask))
    else $error("interrupt low without an enabled flag");
  a_status_read_clear:
  assert property (@(posedge clk) disable iff (rst)
    reg_req.rd && reg_req.addr == lvs_pkg::A_STATUS_READ_CLEAR && set == '0 |=> s.status == '0)
    else $error("clearing read left flags set");

  for (genvar g = 0; g < NP; g++) begin : g_chk
    a_tmo_reload:
    assert property (@(posedge clk) disable iff (rst)
      zx[g] |=> s.tmo[g] == $past(s.zero_cross_timeout_value))
      else $error("timeout counter not reloaded on crossing");
    a_tmo_expire_flag:
    assert property (@(posedge clk) disable iff (rst)
      tick && s.tmo[g] == 16'h1 && !zx[g]
        |=> s.tmo[g] == 16'h0 && s.status[lvs_pkg::TMO_BIT0 + g])
      else $error("expired counter did not raise its flag");
    a_tmo_hold_zero:
    assert property (@(posedge clk) disable iff (rst)
      s.tmo[g] == 16'h0 && !zx[g] |=> s.tmo[g] == 16'h0 && !set[lvs_pkg::TMO_BIT0 + g])
      else $error("expired counter left zero without a crossing");
    a_dip_disabled:
    assert property (@(posedge clk) disable iff (rst)
      s.dip_thr == 8'h0 && !s.status[lvs_pkg::DIP_BIT0 + g]
        |=> !s.status[lvs_pkg::DIP_BIT0 + g])
      else $error("dip flagged with zero threshold");
  end
endmodule : line_voltage_supervisor

// *** verification/volt_source.sv ***
`timescale 1ns/1ps
module volt_source (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // waveform control
  input wire logic run,
  input wire logic [31:0] half_cyc,
  input wire logic [2:0][15:0] amp,
  // sample stream
  output lvs_pkg::volt_in_s volt_in
);
  // slow enough that the 8-deep delay line never overflows at the nominal delay
  localparam int STROBE_GAP = 192;
  int cnt;
  int tick;
  logic neg;
  logic [2:0][15:0] last;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 0;
      tick <= 0;
      // idle level is positive, so the first strobe after reset cannot fake a crossing
      neg <= 1'b0;
      last <= '0;
    end else begin
      tick <= (tick == STROBE_GAP - 1) ? 0 : tick + 1;
      if (volt_in.valid[0]) begin
        last <= volt_in.data;
      end
      if (!run) begin
        // stopped line sits at a positive dc level, so no crossings arrive
        neg <= 1'b0;
      end else if (cnt >= half_cyc - 1) begin
        cnt <= 0;
        neg <= ~neg;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end

  always_comb begin
    volt_in.valid = (tick == 0 && !rst) ? 3'b111 : 3'b000;
    for (int i = 0; i < 3; i++) begin
      // between strobes the data lines hold the inverted last sample, never the last sample itself
      volt_in.data[i] = volt_in.valid[i] ? (neg ? -amp[i] : amp[i]) : ~last[i];
    end
  end
endmodule : volt_source

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // clk_hz chosen so one frequency count per line-rate unit is easy to reckon
  localparam int CLK_HZ_TB = 96000;
  localparam int HALF = 960;
  localparam int PER = 2 * HALF;
  logic clk;
  logic rst;
  logic run;
  int half_cyc;
  logic [2:0][15:0] amp;
  lvs_pkg::reg_req_s req;
  lvs_pkg::reg_rsp_s rsp;
  lvs_pkg::volt_in_s volt_in;
  logic irq_n;
  int errors;
  int checks_done;
  logic [15:0] lfsr;
  logic [23:0] d;
  logic [7:0] ra [9];
  int rw [9];

  volt_source src (
    .clk(clk),
    .rst(rst),
    .run(run),
    .half_cyc(half_cyc),
    .amp(amp),
    .volt_in(volt_in)
  );

  line_voltage_supervisor #(.CLK_HZ(CLK_HZ_TB)) dut (
    .clk(clk),
    .rst(rst),
    .reg_req(req),
    .reg_rsp(rsp),
    .volt_in(volt_in),
    .irq_n(irq_n)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge clk);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [23:0] v);
    @(posedge clk);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    v = rsp.valid ? rsp.data : 24'hxxxxxx;
  endtask : rd

  task automatic rchk(input string name, input logic [7:0] a, input logic [23:0] exp);
    logic [23:0] v;
    rd(a, v);
    chk(name, v, exp);
  endtask : rchk

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #(8 * 80000);
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    lfsr = 16'h1493;
    rst = 1'b1;
    run = 1'b0;
    req = '0;
    half_cyc = HALF;
    amp = {16'h0c00, 16'h0800, 16'h0400};
    ra = '{lvs_pkg::A_ZERO_CROSS_TIMEOUT_VALUE, lvs_pkg::A_CAL_A, lvs_pkg::A_CAL_B, lvs_pkg::A_CAL_C,
      lvs_pkg::A_DIP_THR, lvs_pkg::A_DIP_CYC, lvs_pkg::A_MASK, lvs_pkg::A_MEASUREMENT_MODE_REG,
      lvs_pkg::A_LCMODE};
    rw = '{16, 7, 7, 7, 8, 8, 24, 8, 8};
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rchk("reset_value", ra[i], (i == 0) ? {8'h00, lvs_pkg::ZERO_CROSS_TIMEOUT_VALUE_RST} : 24'h0);
    end
    for (int i = 0; i < 9; i++) begin
      lfsr = lfsr_next(lfsr);
      d = {lfsr[7:0], lfsr} & ((24'h1 << rw[i]) - 24'h1);
      wr(ra[i], d);
      rchk("readback", ra[i], d);
      wr(ra[i], (i == 0) ? 24'h00ffff : 24'h0);
    end
    wr(lvs_pkg::A_VMAX, 24'h000055);
    rchk("ro_write", lvs_pkg::A_VMAX, 24'h0);
    rchk("unmapped", 8'h7f, 24'h0);
    // dip, peak and period on a steady low line
    wr(lvs_pkg::A_DIP_THR, 24'h40);
    wr(lvs_pkg::A_DIP_CYC, 24'h02);
    wr(lvs_pkg::A_MASK, 24'h00000e);
    wr(lvs_pkg::A_MEASUREMENT_MODE_REG, 24'h1c);
    wr(lvs_pkg::A_LCMODE, 24'hb8);
    run = 1'b1;
    cyc(1537 + 8 * PER);
    chk("irq_dip", {23'h0, irq_n}, 24'h0);
    rchk("status_dip", lvs_pkg::A_STATUS_READ_CLEAR, 24'h00000e);
    cyc(2);
    chk("irq_cleared", {23'h0, irq_n}, 24'h1);
    rchk("period", lvs_pkg::A_PERIOD, PER / lvs_pkg::PERIOD_LSB_CYC);
    rchk("vmax_all", lvs_pkg::A_VMAX, 24'h30);
    wr(lvs_pkg::A_LCMODE, 24'h38);
    cyc(6 * PER + 100);
    d = 16 * (CLK_HZ_TB / PER);
    rchk("frequency", lvs_pkg::A_PERIOD, d);
    wr(lvs_pkg::A_MEASUREMENT_MODE_REG, 24'h08);
    cyc(4 * PER + 100);
    rchk("vmax_b", lvs_pkg::A_VMAX, 24'h20);
    // timeouts: crossings keep reloading, then the line goes flat
    wr(lvs_pkg::A_DIP_THR, 24'h00);
    wr(lvs_pkg::A_ZERO_CROSS_TIMEOUT_VALUE, 24'h000008);
    wr(lvs_pkg::A_MASK, 24'h000e00);
    rd(lvs_pkg::A_STATUS_READ_CLEAR, d);
    cyc(2 * PER + 1600);
    rchk("status_running", lvs_pkg::A_STATUS, 24'h0);
    run = 1'b0;
    cyc(6000);
    chk("irq_timeout", {23'h0, irq_n}, 24'h0);
    rchk("status_tmo", lvs_pkg::A_STATUS_READ_CLEAR, 24'h000e00);
    cyc(2000);
    rchk("status_once", lvs_pkg::A_STATUS, 24'h0);
    wr(lvs_pkg::A_MASK, 24'h0);
    run = 1'b1;
    cyc(2 * PER + 1600);
    run = 1'b0;
    cyc(6000);
    chk("irq_masked", {23'h0, irq_n}, 24'h1);
    rchk("status_masked", lvs_pkg::A_STATUS, 24'h000e00);
    report_and_stop();
  end
endmodule : tb_top
